// ### core/vgh_pkg.sv
// Constants, carriers and state codes for the voltage gain, dc-block
// and routing core. Assumes one 50 MHz clock shared by every user.
package vgh_pkg;

	localparam int NUM_CH = 8;
	localparam int SAMPLE_W = 24;
	localparam int GAIN_FRAC = 23;

	// Register addresses
	localparam logic [15:0] ADDR_EVENT_FLAGS_0 = 16'hE502;
	localparam logic [15:0] ADDR_EVENT_ENABLES_0 = 16'hE50A;
	localparam logic [15:0] ADDR_SETUP_WORD = 16'hE618;
	localparam logic [15:0] ADDR_GAIN_BASE = 16'h4380;
	localparam logic [15:0] ADDR_SAMPLE_BASE = 16'hE510;

	// Field positions
	localparam int SAMPLE_READY_BIT = 17;
	localparam int FILTER_ENABLE_BIT = 4;
	localparam int PIN_FN_LSB = 0;
	localparam int ROUTE_A_LSB = 8;
	localparam int ROUTE_B_LSB = 10;
	localparam int ROUTE_C_LSB = 12;
	localparam logic [15:0] SETUP_WORD_RESET = 16'h0010;
	localparam logic [1:0] PIN_FN_READY = 2'h0;

	// Channel order inside a carrier
	localparam logic [2:0] CH_A = 3'h0;
	localparam logic [2:0] CH_B = 3'h2;
	localparam logic [2:0] CH_C = 3'h4;

	// Dc-block corner: larger shift, lower corner, slower settling
	localparam int HPF_SHIFT = 10;
	localparam int HPF_ACC_W = SAMPLE_W + HPF_SHIFT + 2;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int PIN_DELAY_NS = 70;
	localparam int PIN_LOW_US = 10;
	localparam int PIN_DELAY_CYC =
		(PIN_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_LOW_CYC =
		(PIN_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PIN_CNT_W = 10;

	typedef struct packed {
		logic [NUM_CH-1:0][SAMPLE_W-1:0] ch;
	} vgh_volt_t;

	typedef struct packed {
		logic [SAMPLE_W-1:0] a;
		logic [SAMPLE_W-1:0] b;
		logic [SAMPLE_W-1:0] c;
	} vgh_route_t;

	typedef enum logic [1:0] {
		PIN_IDLE = 2'b00,
		PIN_WAIT = 2'b01,
		PIN_LOW = 2'b10
	} vgh_pin_state_t;

endpackage

// ### core/vgh_core.sv
// Voltage channel gain, dc-block filter, waveform capture, sample-ready
// signalling and phase voltage routing.
// Assumes samples arrive as one strobe per 8 kSPS frame on clk, and the
// serial port front end presents single-cycle register strobes on clk.
//
// Operation
// - Each sample times one plus signed 24-bit gain over two to 23.
// - Gain 0x400000 scales up by half, 0xC00000 scales down by half.
// - Gained voltage feeds energy, rms, routing and waveform samples.
// - Gain reads back sign-extended to 28 bits under four zero bits.
// - Setup bit 4 enables all dc-block filters, resets to one.
// - Enabled filter removes dc offset before further computation.
// - Filter outputs captured into eight 24-bit waveform registers per frame.
// - Waveform capture never stalls power and rms datapaths.
// - Sample-ready flag sets once waveform registers hold new samples.
// - Enable bit 17 drives interrupt low while sample-ready flag set.
// - Pin function 00: pin low about 70 ns after flag, 10 us.
// - Pin function 01, 10, 11 shows zero-crossing on shared pin.
// - Waveform registers read as sign-extended 32-bit words.
// - Phase A route field picks A, B, C, A voltage.
// - Phase B route field picks B, C, A, B voltage.
// - Phase C route field picks C, A, B, C voltage.
// - Routed voltage drives that phase's power datapath with own current.
// - Writing one to status bit 17 clears flag, releases interrupt.
`timescale 1ns/1ps
`default_nettype none

module vgh_core
	import vgh_pkg::*;
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire vgh_volt_t adc_sample,
	input wire logic adc_valid,
	input wire logic zero_cross_n,
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_wdata,
	output logic [31:0] reg_rdata,
	output logic reg_rvalid,
	output vgh_volt_t volt_out,
	output logic volt_out_valid,
	output vgh_route_t route_volt,
	output logic filter_enable_out,
	output logic interrupt_line_0_n,
	output logic shared_event_pin
);

	function automatic logic in_block(input logic [15:0] a,
		input logic [15:0] base);
		in_block = (a[15:3] == base[15:3]);
	endfunction

	function automatic logic [SAMPLE_W-1:0] sat24(input logic [25:0] v);
		logic [SAMPLE_W-1:0] r;
		r = v[SAMPLE_W-1:0];
		if (v[25] && (v[24:23] != 2'b11))
			r = {1'b1, {(SAMPLE_W-1){1'b0}}};
		else if (!v[25] && (v[24:23] != 2'b00))
			r = {1'b0, {(SAMPLE_W-1){1'b1}}};
		sat24 = r;
	endfunction

	function automatic logic [SAMPLE_W-1:0] pick(input logic [1:0] fld,
		input logic [SAMPLE_W-1:0] own, input logic [SAMPLE_W-1:0] nxt,
		input logic [SAMPLE_W-1:0] prv);
		case (fld)
			2'h1: pick = nxt;
			2'h2: pick = prv;
			default: pick = own;
		endcase
	endfunction

	logic [NUM_CH-1:0][SAMPLE_W-1:0] gain;
	logic [NUM_CH-1:0][SAMPLE_W-1:0] sample_wave;
	logic [NUM_CH-1:0][SAMPLE_W-1:0] s1_gained;
	logic [NUM_CH-1:0][SAMPLE_W-1:0] gained_all;
	logic [NUM_CH-1:0][SAMPLE_W-1:0] filt;
	logic [NUM_CH-1:0][HPF_ACC_W-1:0] hpf_acc;
	logic [NUM_CH-1:0][HPF_ACC_W-1:0] next_acc;
	logic s1_valid;
	logic [15:0] setup_word;
	logic [31:0] event_enables_0;
	logic sample_ready_flag;
	logic filter_enable_bit;
	logic [1:0] pin_function_field;
	logic [1:0] phase_a_route_field;
	logic [1:0] phase_b_route_field;
	logic [1:0] phase_c_route_field;
	logic flag_clear;
	vgh_pin_state_t pin_state;
	logic [PIN_CNT_W-1:0] pin_cnt;

	assign filter_enable_bit = setup_word[FILTER_ENABLE_BIT];
	assign pin_function_field = setup_word[PIN_FN_LSB +: 2];
	assign phase_a_route_field = setup_word[ROUTE_A_LSB +: 2];
	assign phase_b_route_field = setup_word[ROUTE_B_LSB +: 2];
	assign phase_c_route_field = setup_word[ROUTE_C_LSB +: 2];
	assign flag_clear = reg_wr && (reg_addr == ADDR_EVENT_FLAGS_0)
		&& reg_wdata[SAMPLE_READY_BIT];

	// Register writes
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			setup_word <= SETUP_WORD_RESET;
			event_enables_0 <= 32'h0;
			gain <= '0;
		end else if (ce && reg_wr) begin
			if (reg_addr == ADDR_SETUP_WORD)
				setup_word <= reg_wdata[15:0];
			if (reg_addr == ADDR_EVENT_ENABLES_0)
				event_enables_0 <= reg_wdata;
			if (in_block(reg_addr, ADDR_GAIN_BASE))
				gain[reg_addr[2:0]] <= reg_wdata[SAMPLE_W-1:0];
		end
	end

	// Register reads, one cycle after the strobe
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0;
			reg_rvalid <= 1'b0;
		end else if (ce) begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= 32'h0;
				if (reg_addr == ADDR_EVENT_FLAGS_0)
					reg_rdata[SAMPLE_READY_BIT] <= sample_ready_flag;
				else if (reg_addr == ADDR_EVENT_ENABLES_0)
					reg_rdata <= event_enables_0;
				else if (reg_addr == ADDR_SETUP_WORD)
					reg_rdata <= {16'h0, setup_word};
				else if (in_block(reg_addr, ADDR_GAIN_BASE))
					reg_rdata <= {4'h0,
						{4{gain[reg_addr[2:0]][SAMPLE_W-1]}},
						gain[reg_addr[2:0]]};
				else if (in_block(reg_addr, ADDR_SAMPLE_BASE))
					reg_rdata <= {{8{sample_wave[reg_addr[2:0]][SAMPLE_W-1]}},
						sample_wave[reg_addr[2:0]]};
			end
		end
	end

	// Per-channel gain multiply and dc-block filter
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			logic signed [47:0] prod;
			logic [25:0] gsum;
			logic [25:0] hdiff;
			logic [SAMPLE_W-1:0] hout;
			// Product stays within 25 bits after the shift since |g| <= 2^23
			assign prod = $signed(adc_sample.ch[gi]) * $signed(gain[gi]);
			assign gsum = {{2{adc_sample.ch[gi][SAMPLE_W-1]}}, adc_sample.ch[gi]}
				+ {prod[47], prod[47:GAIN_FRAC]};
			assign gained_all[gi] = sat24(gsum);
			assign hdiff = {{2{s1_gained[gi][SAMPLE_W-1]}}, s1_gained[gi]}
				- hpf_acc[gi][HPF_ACC_W-1:HPF_SHIFT];
			assign hout = sat24(hdiff);
			assign filt[gi] = filter_enable_bit ? hout : s1_gained[gi];
			assign next_acc[gi] = hpf_acc[gi]
				+ {{(HPF_ACC_W-SAMPLE_W){hout[SAMPLE_W-1]}}, hout};
		end
	endgenerate

	// Gain stage
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			s1_gained <= '0;
			s1_valid <= 1'b0;
		end else if (ce) begin
			s1_valid <= adc_valid;
			if (adc_valid)
				s1_gained <= gained_all;
		end
	end

	// Filter state; cleared while bypassed so re-enable starts clean
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hpf_acc <= '0;
		end else if (ce && s1_valid) begin
			if (filter_enable_bit)
				hpf_acc <= next_acc;
			else
				hpf_acc <= '0;
		end
	end

	// Capture, datapath and routing outputs on every frame
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sample_wave <= '0;
			volt_out <= '0;
			volt_out_valid <= 1'b0;
			route_volt <= '0;
		end else if (ce) begin
			volt_out_valid <= s1_valid;
			if (s1_valid) begin
				sample_wave <= filt;
				volt_out.ch <= filt;
				route_volt.a <= pick(phase_a_route_field, filt[CH_A],
					filt[CH_B], filt[CH_C]);
				route_volt.b <= pick(phase_b_route_field, filt[CH_B],
					filt[CH_C], filt[CH_A]);
				route_volt.c <= pick(phase_c_route_field, filt[CH_C],
					filt[CH_A], filt[CH_B]);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			filter_enable_out <= 1'b1;
		else if (ce)
			filter_enable_out <= filter_enable_bit;
	end

	// Sample-ready flag; a new frame wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (sys_rst)
			sample_ready_flag <= 1'b0;
		else if (ce) begin
			if (s1_valid)
				sample_ready_flag <= 1'b1;
			else if (flag_clear)
				sample_ready_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst)
			interrupt_line_0_n <= 1'b1;
		else if (ce)
			interrupt_line_0_n <= ~(sample_ready_flag
				&& event_enables_0[SAMPLE_READY_BIT]);
	end

	// Shared pin sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pin_state <= PIN_IDLE;
			pin_cnt <= '0;
		end else if (ce) begin
			case (pin_state)
				PIN_IDLE: begin
					pin_cnt <= '0;
					if (s1_valid && pin_function_field == PIN_FN_READY)
						pin_state <= PIN_WAIT;
				end
				PIN_WAIT: begin
					if (pin_cnt == PIN_CNT_W'(PIN_DELAY_CYC - 1)) begin
						pin_state <= PIN_LOW;
						pin_cnt <= '0;
					end else
						pin_cnt <= pin_cnt + 1'b1;
				end
				PIN_LOW: begin
					if (pin_cnt == PIN_CNT_W'(PIN_LOW_CYC - 1)) begin
						pin_state <= PIN_IDLE;
						pin_cnt <= '0;
					end else
						pin_cnt <= pin_cnt + 1'b1;
				end
				default: begin
					pin_state <= PIN_IDLE;
					pin_cnt <= '0;
				end
			endcase
		end
	end

	// Zero-crossing input comes from logic on clk, so no synchroniser
	always_ff @(posedge clk) begin
		if (sys_rst)
			shared_event_pin <= 1'b1;
		else if (ce) begin
			if (pin_function_field != PIN_FN_READY)
				shared_event_pin <= zero_cross_n;
			else if (pin_state == PIN_WAIT
				&& pin_cnt == PIN_CNT_W'(PIN_DELAY_CYC - 1))
				shared_event_pin <= 1'b0;
			else if (pin_state != PIN_LOW)
				shared_event_pin <= 1'b1;
			else if (pin_cnt == PIN_CNT_W'(PIN_LOW_CYC - 1))
				shared_event_pin <= 1'b1;
		end
	end

	// Checks
	logic [PIN_CNT_W:0] low_run;
	always_ff @(posedge clk) begin
		if (sys_rst)
			low_run <= '0;
		else if (ce) begin
			if (shared_event_pin)
				low_run <= '0;
			else
				low_run <= low_run + 1'b1;
		end
	end

	AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid) |=> sample_ready_flag)
		else $error("sample-ready flag not set after capture");
	AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && flag_clear && !s1_valid) |=> !sample_ready_flag)
		else $error("sample-ready flag not cleared by write");
	AST_IRQ: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && sample_ready_flag && event_enables_0[SAMPLE_READY_BIT])
		|=> !interrupt_line_0_n)
		else $error("interrupt not raised");
	AST_PIN_DELAY: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && pin_state == PIN_WAIT && pin_cnt == '0
		&& pin_function_field == PIN_FN_READY)
		##1 (ce && pin_function_field == PIN_FN_READY) [*3]
		|=> !shared_event_pin)
		else $error("shared pin not low after delay");
	AST_PIN_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
		($rose(shared_event_pin) && $past(pin_state) == PIN_LOW
		&& pin_function_field == PIN_FN_READY)
		|-> low_run == (PIN_CNT_W+1)'(PIN_LOW_CYC))
		else $error("shared pin low width wrong");
	AST_ZX_MODE: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && pin_function_field != PIN_FN_READY)
		|=> shared_event_pin == $past(zero_cross_n))
		else $error("shared pin not following zero crossing");
	AST_BYPASS: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid && !filter_enable_bit)
		|=> sample_wave[CH_A] == $past(s1_gained[CH_A]))
		else $error("bypassed filter altered sample");
	AST_GAIN_HALF: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && adc_valid && gain[CH_A] == 24'h400000
		&& adc_sample.ch[CH_A][23:21] == 3'h0)
		|=> s1_gained[CH_A] == $past(adc_sample.ch[CH_A]
		+ {1'b0, adc_sample.ch[CH_A][23:1]}))
		else $error("gain of one half wrong");
	AST_ROUTE_A: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid && phase_a_route_field == 2'h1)
		|=> route_volt.a == $past(filt[CH_B]))
		else $error("phase A route wrong");
	AST_READ_GAIN: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && reg_rd && !reg_wr && reg_addr == ADDR_GAIN_BASE)
		|=> reg_rdata == {4'h0, {4{$past(gain[0][23])}}, $past(gain[0])})
		else $error("gain readback format wrong");
	AST_READ_WAVE: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && reg_rd && reg_addr == ADDR_SAMPLE_BASE)
		|=> reg_rdata[31:23] == {9{$past(sample_wave[0][23])}})
		else $error("waveform readback not sign extended");
	AST_ROUTE_B: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid && phase_b_route_field == 2'h2)
		|=> route_volt.b == $past(filt[CH_A]))
		else $error("phase B route wrong");
	AST_ROUTE_C: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid && phase_c_route_field == 2'h1)
		|=> route_volt.c == $past(filt[CH_A]))
		else $error("phase C route wrong");
	AST_WAVE_CAP: assert property (@(posedge clk) disable iff (sys_rst)
		(ce && s1_valid) |=> sample_wave == $past(filt))
		else $error("waveform registers not captured");
	// Low clock enable freezes volt_out, the shared pin, reg_rvalid and the interrupt line
	AST_CE_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
		!ce |=> $stable(volt_out) && $stable(shared_event_pin)
		&& $stable(reg_rvalid) && $stable(interrupt_line_0_n))
		else $error("state moved while clock enable low");

	COV_PIN_PULSE: cover property (@(posedge clk) disable iff (sys_rst)
		$rose(shared_event_pin) && $past(pin_state) == PIN_LOW);
	COV_CLEAR_SET: cover property (@(posedge clk) disable iff (sys_rst)
		ce && s1_valid && flag_clear);
	COV_IRQ: cover property (@(posedge clk) disable iff (sys_rst)
		$fell(interrupt_line_0_n));
	COV_ROUTE_SWAP: cover property (@(posedge clk) disable iff (sys_rst)
		ce && s1_valid && phase_b_route_field == 2'h2);

endmodule

`default_nettype wire

// ### tb/vgh_host.sv
// Host model: drives the register strobe port and burst reads samples.
// Assumes the core answers a read within four clk cycles.
`timescale 1ns/1ps
`default_nettype none
module vgh_host
	import vgh_pkg::*;
(
	input wire logic clk,
	input wire logic [31:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic shared_event_pin,
	output logic [15:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [31:0] reg_wdata
);
	logic burst_en = 1'b0;
	int burst_n = 0;
	logic [31:0] burst [NUM_CH];
	initial begin
		reg_addr = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 32'h00000000;
	end
	// Idle bus shows the inverse so a stale value never looks valid
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~d;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		int n;
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		reg_addr = ~a;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge clk);
			#1;
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 32'hXXXXXXXX;
	endtask
	always @(posedge shared_event_pin) begin
		if (burst_en) begin
			for (int i = 0; i < NUM_CH; i++) begin
				rd(ADDR_SAMPLE_BASE + 16'(i), burst[i]);
				burst_n++;
			end
		end
	end
endmodule
`default_nettype wire

// ### tb/voltage_channel_gain_hpf_router_tb.sv
// Self-checking bench for the voltage gain, dc-block and routing core.
// Assumes vgh_host as register master and a 50 MHz clk.
`timescale 1ns/1ps
`default_nettype none
module voltage_channel_gain_hpf_router_tb
	import vgh_pkg::*;
();
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	vgh_volt_t adc_sample = '0;
	logic adc_valid = 1'b0;
	logic zero_cross_n = 1'b1;
	logic [15:0] reg_addr;
	logic reg_wr, reg_rd, reg_rvalid, volt_out_valid, filter_enable_out;
	logic [31:0] reg_wdata, reg_rdata, d;
	vgh_volt_t volt_out, s;
	vgh_route_t route_volt;
	logic interrupt_line_0_n, shared_event_pin;
	logic [23:0] g [NUM_CH];
	logic [23:0] e;
	logic [1:0] k, fn;
	int n_fail = 0;
	int cmp_count = 0;
	int n, m;
	always #10 clk = ~clk;
	vgh_core dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce),
		.adc_sample(adc_sample), .adc_valid(adc_valid),
		.zero_cross_n(zero_cross_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .volt_out(volt_out),
		.volt_out_valid(volt_out_valid), .route_volt(route_volt),
		.filter_enable_out(filter_enable_out),
		.interrupt_line_0_n(interrupt_line_0_n),
		.shared_event_pin(shared_event_pin));
	vgh_host host_u (.clk(clk), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .shared_event_pin(shared_event_pin),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_wdata(reg_wdata));
	task automatic chk(input string w, input logic [31:0] x,
		input logic [31:0] y);
		cmp_count++;
		if (y !== x) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", w, x, y);
		end
	endtask
	// Sample compare allows one LSB, rounding mode is left open
	task automatic chk_near(input string w, input logic [23:0] x,
		input logic [23:0] y);
		cmp_count++;
		if (!(y === x || y === x + 24'h1 || y === x - 24'h1)) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", w, x, y);
		end
	endtask
	function automatic logic [23:0] gained(input logic [23:0] x,
		input logic [23:0] gv);
		longint p;
		p = (longint'($signed(x)) * (longint'($signed(gv)) + 64'sd8388608));
		p = p >>> 23;
		if (p > 64'sd8388607) p = 64'sd8388607;
		if (p < -64'sd8388608) p = -64'sd8388608;
		return p[23:0];
	endfunction
	task automatic frame(input vgh_volt_t v);
		int c;
		@(posedge clk);
		#1;
		adc_sample = v;
		adc_valid = 1'b1;
		@(posedge clk);
		#1;
		adc_valid = 1'b0;
		adc_sample = ~v;
		c = 0;
		while (volt_out_valid !== 1'b1 && c < 8) begin
			@(posedge clk);
			#1;
			c++;
		end
		chk("volt_valid", 32'h1, {31'h0, volt_out_valid});
	endtask
	task automatic rnd_frame();
		for (int i = 0; i < NUM_CH; i++) s.ch[i] = 24'($urandom);
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#1200000;
		n_fail++;
		$display("[ERR] watchdog expected done seen timeout");
		results();
	end
	initial begin
		n = $urandom(56168);
		repeat (10) @(posedge clk);
		#1;
		sys_rst = 1'b0;
		host_u.rd(ADDR_SETUP_WORD, d);
		chk("setup_rst", 32'h00000010, d);
		chk("flt_rst", 32'h1, {31'h0, filter_enable_out});
		host_u.rd(16'h0000, d);
		chk("unmapped", 32'h0, d);
		// Gains, bypassed filter, pin function 00
		for (int i = 0; i < NUM_CH; i++) begin
			g[i] = (i == 0) ? 24'h400000 : (i == 1) ? 24'hC00000 : 24'($urandom);
			host_u.wr(ADDR_GAIN_BASE + 16'(i), {4'h0, {4{g[i][23]}}, g[i]});
		end
		host_u.wr(ADDR_SETUP_WORD, 32'h00000000);
		host_u.wr(ADDR_EVENT_ENABLES_0, 32'h00020000);
		chk("flt_off", 32'h0, {31'h0, filter_enable_out});
		rnd_frame();
		s.ch[0] = 24'h100000;
		s.ch[1] = 24'h7FFFFF;
		frame(s);
		for (int i = 0; i < NUM_CH; i++)
			chk_near("volt", gained(s.ch[i], g[i]), volt_out.ch[i]);
		n = 0;
		while (shared_event_pin !== 1'b0 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("pin_delay", 32'h1, {31'h0, n >= 1 && n <= 5});
		m = 0;
		while (shared_event_pin === 1'b0 && m < 600) begin
			@(posedge clk);
			#1;
			m++;
		end
		chk_near("pin_low", 24'(PIN_LOW_CYC), 24'(m));
		host_u.rd(ADDR_EVENT_FLAGS_0, d);
		chk("flag_set", 32'h1, {31'h0, d[17]});
		chk("irq_low", 32'h0, {31'h0, interrupt_line_0_n});
		for (int i = 0; i < NUM_CH; i++) begin
			host_u.rd(ADDR_GAIN_BASE + 16'(i), d);
			chk("gain_rd", {4'h0, {4{g[i][23]}}, g[i]}, d);
			host_u.rd(ADDR_SAMPLE_BASE + 16'(i), d);
			e = gained(s.ch[i], g[i]);
			chk_near("wave", e, d[23:0]);
			chk("wave_sx", {24'h0, {8{e[23]}}}, {24'h0, d[31:24]});
		end
		host_u.wr(ADDR_EVENT_FLAGS_0, 32'h00020000);
		host_u.rd(ADDR_EVENT_FLAGS_0, d);
		chk("flag_clr", 32'h0, {31'h0, d[17]});
		chk("irq_rel", 32'h1, {31'h0, interrupt_line_0_n});
		// Masked interrupt, burst read on the pin's rising edge
		host_u.wr(ADDR_EVENT_ENABLES_0, 32'h00000000);
		host_u.burst_en = 1'b1;
		rnd_frame();
		frame(s);
		n = 0;
		while (host_u.burst_n < NUM_CH && n < 800) begin
			@(posedge clk);
			#1;
			n++;
		end
		host_u.burst_en = 1'b0;
		chk("irq_masked", 32'h1, {31'h0, interrupt_line_0_n});
		for (int i = 0; i < NUM_CH; i++) begin
			e = gained(s.ch[i], g[i]);
			chk_near("burst", e, host_u.burst[i][23:0]);
		end
		host_u.wr(ADDR_EVENT_FLAGS_0, 32'h00020000);
		// Every route code, zero-crossing pin functions
		for (int r = 0; r < 4; r++) begin
			k = 2'(r);
			fn = (k == 2'h0) ? 2'h1 : k;
			host_u.wr(ADDR_SETUP_WORD, {18'h0, k, k, k, 6'h0, fn});
			rnd_frame();
			frame(s);
			for (int p = 0; p < 3; p++) begin
				n = (k == 2'h3) ? p : (p + r) % 3;
				e = gained(s.ch[2 * n], g[2 * n]);
				chk_near("route", e, route_volt[71 - 24 * p -: 24]);
			end
			zero_cross_n = 1'($urandom);
			repeat (3) @(posedge clk);
			#1;
			chk("zx_pin", {31'h0, zero_cross_n}, {31'h0, shared_event_pin});
		end
		// Dc input with the filter on, frames back to back
		host_u.wr(ADDR_SETUP_WORD, 32'h00000011);
		@(posedge clk);
		#1;
		chk("flt_on", 32'h1, {31'h0, filter_enable_out});
		for (int i = 0; i < NUM_CH; i++) s.ch[i] = 24'h100000;
		repeat (5000) frame(s);
		e = volt_out.ch[0];
		m = $signed(e);
		chk("dc_removed", 32'h1, {31'h0, m < 65536 && m > -65536});
		// Low clock enable must swallow a frame strobe
		@(posedge clk);
		#1;
		ce = 1'b0;
		adc_valid = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk("ce_hold", 32'h0, {31'h0, volt_out_valid});
		adc_valid = 1'b0;
		ce = 1'b1;
		results();
	end
endmodule
`default_nettype wire
